/* File: dv/asc_analog_model.sv */
// Model of the analog inputs behind the approximation core.
`timescale 1ns/1ps
module asc_analog_model
  import asc_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire asc_core_req_type core_req, // Request.
  output logic [9:0] core_code = 10'h155 // Code.
);
  // Each channel holds its own level while sampled; outside a sample the code toggles so a late capture shows.
  always_ff @(posedge pclk)
  begin
    if (core_req.sample)
      core_code <= {core_req.chan, 7'h2D};
    else
      core_code <= ~core_code;
  end
endmodule : asc_analog_model

/* File: dv/asc_monitor.sv */
// Port assertions of the converter sequencer.
`timescale 1ns/1ps
module asc_monitor
  import asc_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Access.
  input wire logic pwrite, // Write.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Data in.
  input wire logic [31:0] prdata, // Data out.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic standby_enter, // Standby.
  input wire logic [9:0] core_code, // Code.
  input wire asc_core_req_type core_req, // Request.
  input wire logic conversion_done_irq // Pulse.
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A launch must keep sampling; a counter that never loads ends it at once.
  sequence launch_seq;
    $rose(core_req.sample);
  endsequence
  sequence hold_seq;
    core_req.sample [*8];
  endsequence
  chk_busy_min: assert property (launch_seq |-> hold_seq)
    else $error("busy too short");
  chk_irq_pulse: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("pulse too long");
  chk_irq_after_busy: assert property (conversion_done_irq |-> $past(core_req.sample))
    else $error("pulse without busy");
  chk_chan_stable: assert property (core_req.sample && $past(core_req.sample) |-> $stable(core_req.chan))
    else $error("channel moved");
  chk_standby_quiet: assert property (standby_enter [*4] |-> !core_req.sample && !core_req.ref_connect)
    else $error("standby not quiet");
  chk_unmapped_err: assert property (psel && penable && paddr > ASC_OFF_SAMPLE |-> pslverr)
    else $error("no error");
  chk_idle_rdata: assert property (!(psel && penable) |-> prdata == 32'h0)
    else $error("idle data");
  chk_ctrl_two_bits: assert property (psel && penable && !pwrite && paddr == ASC_OFF_CTRL_TWO |-> prdata[4] && !prdata[0])
    else $error("fixed bits");
endmodule : asc_monitor

/* File: dv/asc_top_tb.sv */
// Self-checking bench of the converter sequencer.
`timescale 1ns/1ps
module asc_top_tb
  import asc_pkg::*;
;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic standby_enter = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, conversion_done_irq;
  logic [9:0] core_code;
  asc_core_req_type core_req;
  int bad_count = 0;
  int cmp_count = 0;
  int n;

  asc_top u_asc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .standby_enter, .core_code, .core_req, .conversion_done_irq);
  asc_analog_model u_asc_analog_model (.pclk, .core_req, .core_code);

  // Clock of 100 ns.
  initial
  begin
    forever #50 pclk = ~pclk;
  end

  // Compare and count.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One transfer, held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d = 32'h0);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Counts edges up to the next pulse; the bound stops a hang.
  task automatic wait_irq;
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (conversion_done_irq !== 1'h1 && n < 3000);
  endtask : wait_irq

  // Every non-reserved time code once, result read lower first.
  task automatic t_times;
    logic [2:0] code [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    int cyc [6] = '{39, 78, 156, 312, 624, 1248};
    logic [9:0] x;
    for (int i = 0; i < 6; i++)
    begin
      x = {i[2:0], 7'h2D};
      apb(1'h1, ASC_OFF_CTRL_TWO, {i[0], 1'h1, code[i], 1'h0});
      apb(1'h1, ASC_OFF_CTRL_ONE, {5'h14, i[2:0]});
      wait_irq();
      chk("cycles", cyc[i] + 1, n);
      apb(1'h0, ASC_OFF_RESULT_LOWER);
      chk("status", {x[1:0], 2'h2}, rd[7:4]);
      apb(1'h0, ASC_OFF_RESULT_UPPER);
      chk("upper", x[9:2], rd);
      apb(1'h0, ASC_OFF_RESULT_LOWER);
      chk("done", 1'h0, rd[5]);
      apb(1'h0, ASC_OFF_CTRL_ONE);
      chk("start", {5'h04, i[2:0]}, rd);
      chk("ladder", i[0], core_req.ref_connect);
    end
  endtask : t_times

  // A restart before reading keeps the old result.
  task automatic t_restart;
    apb(1'h1, ASC_OFF_CTRL_TWO, 32'h10);
    apb(1'h1, ASC_OFF_CTRL_ONE, 32'hA2);
    wait_irq();
    apb(1'h1, ASC_OFF_CTRL_ONE, 32'hA6);
    apb(1'h0, ASC_OFF_RESULT_LOWER);
    chk("relaunch", 4'h5, rd[7:4]);
    apb(1'h0, ASC_OFF_RESULT_UPPER);
    chk("old", 32'h4B, rd);
    wait_irq();
    apb(1'h0, ASC_OFF_RESULT_UPPER);
    chk("new", 32'hCB, rd);
  endtask : t_restart

  // Repeat relaunches alone; disable stops it mid-flight.
  task automatic t_repeat;
    apb(1'h1, ASC_OFF_CTRL_ONE, 32'hE5);
    wait_irq();
    wait_irq();
    chk("gap", 32'h27, n);
    apb(1'h0, ASC_OFF_RESULT_UPPER);
    repeat (10) @(posedge pclk);
    apb(1'h1, ASC_OFF_CTRL_ONE, 32'h05);
    repeat (60) @(posedge pclk);
    apb(1'h0, ASC_OFF_RESULT_LOWER);
    chk("abort", 4'h4, rd[7:4]);
  endtask : t_repeat

  // Standby mid-conversion wipes setup and results.
  task automatic t_standby;
    apb(1'h1, ASC_OFF_CTRL_TWO, 32'h30);
    apb(1'h1, ASC_OFF_CTRL_ONE, 32'hA1);
    repeat (10) @(posedge pclk);
    standby_enter <= 1'h1;
    repeat (4) @(posedge pclk);
    #1;
    chk("sb_busy", 32'h0, core_req.sample);
    chk("sb_ref", 32'h0, core_req.ref_connect);
    apb(1'h1, ASC_OFF_CTRL_ONE, 32'hA1);
    standby_enter <= 1'h0;
    repeat (60) @(posedge pclk);
    apb(1'h0, ASC_OFF_CTRL_ONE);
    chk("ctrl_one", ASC_CTRL_ONE_RESET, rd);
    apb(1'h0, ASC_OFF_CTRL_TWO);
    chk("ctrl_two", 32'h10, rd);
    apb(1'h0, ASC_OFF_RESULT_UPPER);
    chk("result", 32'h0, rd);
    chk("idle", 32'h0, core_req.sample);
    apb(1'h0, 8'h14);
    chk("slverr", 32'h1, err);
    chk("ready", 32'h1, pready);
  endtask : t_standby

  // Verdict and end of run.
  task automatic stop_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Reset for eight cycles, then the scenarios.
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_times();
    t_restart();
    t_repeat();
    t_standby();
    stop_test();
  end

  // Watchdog well beyond the few thousand cycles needed.
  initial
  begin
    repeat (10000) @(posedge pclk);
    bad_count++;
    stop_test();
  end
endmodule : asc_top_tb

bind asc_top asc_monitor u_asc_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .standby_enter, .core_code, .core_req, .conversion_done_irq);

/* File: include/asc_pkg.sv */
// Package with register map, field layout and timing constants of the converter sequencer.
package asc_pkg;

  // Register byte offsets on the APB word map.
  localparam logic [7:0] ASC_OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] ASC_OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] ASC_OFF_RESULT_UPPER = 8'h08;
  localparam logic [7:0] ASC_OFF_RESULT_LOWER = 8'h0C;
  localparam logic [7:0] ASC_OFF_SAMPLE = 8'h10;

  // Control one field positions.
  localparam int ASC_START_POS = 7;
  localparam int ASC_MODE_POS = 5;
  localparam int ASC_AIN_DIS_POS = 4;
  localparam int ASC_CHAN_POS = 0;

  // Control two field positions.
  localparam int ASC_LADDER_POS = 5;
  localparam int ASC_CTIME_POS = 1;

  // Result lower/status field positions.
  localparam int ASC_LOW_POS = 6;
  localparam int ASC_DONE_POS = 5;
  localparam int ASC_BUSY_POS = 4;

  // Values after reset.
  localparam logic [7:0] ASC_CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] ASC_CTRL_TWO_RESET = 8'h00;
  localparam logic [9:0] ASC_RESULT_RESET = 10'h000;

  // Operating mode codes.
  typedef enum logic [1:0] {
    ASC_MODE_DISABLE = 2'h0,
    ASC_MODE_SOFT = 2'h1,
    ASC_MODE_RESV = 2'h2,
    ASC_MODE_REPEAT = 2'h3
  } asc_mode_type;

  // Conversion times in fc cycles.
  localparam logic [10:0] ASC_CYC_39 = 11'd39;
  localparam logic [10:0] ASC_CYC_78 = 11'd78;
  localparam logic [10:0] ASC_CYC_156 = 11'd156;
  localparam logic [10:0] ASC_CYC_312 = 11'd312;
  localparam logic [10:0] ASC_CYC_624 = 11'd624;
  localparam logic [10:0] ASC_CYC_1248 = 11'd1248;

  // Control register one contents.
  typedef struct packed {
    logic start;
    asc_mode_type mode;
    logic ain_disable;
    logic [3:0] chan;
  } asc_ctrl_one_type;

  // Control register two contents.
  typedef struct packed {
    logic ladder_always;
    logic [2:0] ctime;
  } asc_ctrl_two_type;

  // Request to the analog core.
  typedef struct packed {
    logic sample;
    logic [2:0] chan;
    logic ref_connect;
  } asc_core_req_type;

endpackage : asc_pkg

/* File: verilog/asc_top.sv */
// Sequencing and register logic of a 10-bit successive-approximation converter.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

// What this block does
// RULE_01: Start bit in software mode begins one conversion of the selected channel.
// RULE_02: At completion result, done flag and interrupt all update together.
// RULE_03: Start bit clears itself once the conversion has begun.
// RULE_04: Software must not restart while busy; wait for done or interrupt.
// RULE_05: Repeat mode relaunches a conversion after each completion without new starts.
// RULE_06: Writing the disable mode aborts at once and drops the partial result.
// RULE_07: Result, done flag and interrupt appear only after the selected time.
// RULE_08: Reading the result clears done; old result stays until next completion.
// RULE_09: Standby aborts, resets both control registers and clears results.
// RULE_10: After standby nothing restarts; software must set up and start again.
// RULE_11: Standby disconnects the reference ladder.
// RULE_12: Each result is an unsigned 10-bit value.
// RULE_13: Software sets channel, input, mode, time and ladder before starting.
// RULE_14: Software should avoid port activity during conversion.
// RULE_15: Upper 8 result bits in upper register, lower 2 in lower register.
// RULE_16: Three-bit code picks 39 to 1248 fc cycles; two codes reserved.
// RULE_17: Ladder bit: 0 connects only during conversion, 1 always.
// RULE_18: Reading upper result clears done; read lower register first.
// RULE_19: Busy sets at start, clears at finish and on standby entry. In repeat mode the code keeps busy set across each completion.
// RULE_20: A counter on fc, loaded from the time code, times each conversion.
module asc_top
  import asc_pkg::*;
(
  input wire logic pclk, // System clock fc.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic standby_enter, // Level: device in STOP or SLOW mode.
  input wire logic [9:0] core_code, // Code from the approximation core.
  output asc_core_req_type core_req, // Sample, channel and ladder to the analog side.
  output logic conversion_done_irq // Completion pulse.
);

  asc_ctrl_one_type adc_control_one_reg;
  asc_ctrl_two_type adc_control_two_reg;
  logic [9:0] result_reg;
  logic done_reg;
  logic busy_reg;
  logic irq_reg;
  logic [10:0] count_reg;
  logic stby_meta_reg;
  logic stby_reg;
  logic setup_ok;
  logic wr_en;
  logic rd_en;
  logic launch;
  logic finish;
  logic abort;
  logic [9:0] core_meta_reg;
  logic [9:0] core_sync_reg;

  // Map a time code to its cycle count; reserved codes give zero.
  function automatic logic [10:0] asc_cycles(input logic [2:0] code);
    unique case (code)
      3'h0: asc_cycles = ASC_CYC_39;
      3'h2: asc_cycles = ASC_CYC_78;
      3'h3: asc_cycles = ASC_CYC_156;
      3'h4: asc_cycles = ASC_CYC_312;
      3'h5: asc_cycles = ASC_CYC_624;
      3'h6: asc_cycles = ASC_CYC_1248;
      default: asc_cycles = 11'h000;
    endcase
  endfunction : asc_cycles

  // Decode whether an address hits a mapped register.
  function automatic logic asc_mapped(input logic [7:0] addr);
    asc_mapped = (addr == ASC_OFF_CTRL_ONE) || (addr == ASC_OFF_CTRL_TWO) ||
                 (addr == ASC_OFF_RESULT_UPPER) || (addr == ASC_OFF_RESULT_LOWER) ||
                 (addr == ASC_OFF_SAMPLE);
  endfunction : asc_mapped

  // Standby arrives from the power controller in another timing domain, so it is synchronised.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stby_meta_reg <= 1'b0;
      stby_reg <= 1'b0;
    end
    else
    begin
      stby_meta_reg <= standby_enter;
      stby_reg <= stby_meta_reg;
    end
  end

  // The core code is an analog-side output and is synchronised likewise.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_meta_reg <= ASC_RESULT_RESET;
      core_sync_reg <= ASC_RESULT_RESET;
    end
    else
    begin
      core_meta_reg <= core_code;
      core_sync_reg <= core_meta_reg;
    end
  end

  // Bus strobes; the slave always answers in the access cycle.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !asc_mapped(paddr);

  // A reserved time code or reserved channel cannot start a conversion.
  assign setup_ok = (asc_cycles(adc_control_two_reg.ctime) != 11'h000) && !adc_control_one_reg.chan[3];

  // Start handling per mode; repeat mode relaunches on completion.
  assign launch = !busy_reg && !stby_reg && setup_ok && adc_control_one_reg.start &&
                  (adc_control_one_reg.mode == ASC_MODE_SOFT ||
                   adc_control_one_reg.mode == ASC_MODE_REPEAT); // RULE_01
  assign finish = busy_reg && (count_reg == 11'h001) && !abort; // RULE_07
  assign abort = stby_reg || (wr_en && paddr == ASC_OFF_CTRL_ONE &&
                 pwdata[ASC_MODE_POS +: 2] == ASC_MODE_DISABLE); // RULE_06

  // Control register one; writes are locked out during standby.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      adc_control_one_reg <= asc_ctrl_one_type'(ASC_CTRL_ONE_RESET);
    else if (stby_reg)
      adc_control_one_reg <= asc_ctrl_one_type'(ASC_CTRL_ONE_RESET); // RULE_09 RULE_10
    else if (wr_en && paddr == ASC_OFF_CTRL_ONE)
      adc_control_one_reg <= asc_ctrl_one_type'(pwdata[7:0]);
    else if (launch)
      adc_control_one_reg.start <= 1'b0; // RULE_03
  end

  // Control register two; reset to initial value by standby too.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      adc_control_two_reg <= asc_ctrl_two_type'(ASC_CTRL_TWO_RESET[3:0]);
    else if (stby_reg)
      adc_control_two_reg <= asc_ctrl_two_type'(ASC_CTRL_TWO_RESET[3:0]); // RULE_09
    else if (wr_en && paddr == ASC_OFF_CTRL_TWO)
      adc_control_two_reg <= {pwdata[ASC_LADDER_POS], pwdata[ASC_CTIME_POS +: 3]}; // RULE_16 RULE_17
  end

  // Busy flag and conversion counter, loaded from the time code.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_reg <= 1'b0;
      count_reg <= 11'h000;
    end
    else if (abort)
    begin
      busy_reg <= 1'b0; // RULE_19
      count_reg <= 11'h000;
    end
    else if (finish && adc_control_one_reg.mode == ASC_MODE_REPEAT)
      count_reg <= asc_cycles(adc_control_two_reg.ctime); // RULE_05 RULE_20
    else if (finish)
    begin
      busy_reg <= 1'b0; // RULE_19
      count_reg <= 11'h000;
    end
    else if (launch)
    begin
      busy_reg <= 1'b1; // RULE_19
      count_reg <= asc_cycles(adc_control_two_reg.ctime); // RULE_20
    end
    else if (busy_reg)
      count_reg <= count_reg - 11'h001; // RULE_20
  end

  // Result capture; a partial result is never stored and standby clears it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_reg <= ASC_RESULT_RESET;
    else if (stby_reg)
      result_reg <= ASC_RESULT_RESET; // RULE_09
    else if (finish)
      result_reg <= core_sync_reg; // RULE_02 RULE_12
  end

  // Done flag: completion sets it, reading the upper result or restarting clears it; set wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_reg <= 1'b0;
    else if (finish)
      done_reg <= 1'b1; // RULE_02
    else if (stby_reg || launch || (rd_en && paddr == ASC_OFF_RESULT_UPPER))
      done_reg <= 1'b0; // RULE_08 RULE_18
  end

  // Completion interrupt, one cycle wide, coincident with result and done.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= finish; // RULE_02
  end

  assign conversion_done_irq = irq_reg;

  // Analog side request; ladder is dropped in standby regardless of the control bit.
  always_comb
  begin
    core_req.sample = busy_reg;
    core_req.chan = adc_control_one_reg.chan[2:0];
    core_req.ref_connect = !stby_reg && (busy_reg || adc_control_two_reg.ladder_always); // RULE_11 RULE_17
  end

  // Read mux; lower status register returns low result bits, done and busy.
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
      unique case (paddr)
        ASC_OFF_CTRL_ONE: prdata[7:0] = adc_control_one_reg;
        ASC_OFF_CTRL_TWO: prdata[7:0] = {2'h0, adc_control_two_reg.ladder_always, 1'b1,
                                          adc_control_two_reg.ctime, 1'b0};
        ASC_OFF_RESULT_UPPER: prdata[7:0] = result_reg[9:2]; // RULE_15
        ASC_OFF_RESULT_LOWER: prdata[7:0] = {result_reg[1:0], done_reg, busy_reg, 4'h0}; // RULE_15
        ASC_OFF_SAMPLE: prdata[9:0] = core_sync_reg;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : asc_top
